//--- hdl/host_port_defines.svh
// timing counts and field positions for the asynchronous host port
// assumes a 25 mhz core clock (40 ns period)
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH
`define CLK_PERIOD_NS       40
`define RESET_MIN_NS        100
// least time, rounded up
`define RESET_FILTER_CYC    ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READY_MIN_NS        100
`define READY_MAX_NS        150
// ready low time: at least the minimum, within the maximum
`define READY_HOLD_CYC      ((`READY_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INT_SEL_LSB         0
`define INT_SEL_MSB         1
`define INT_SEL_PIN         2'h0
`define BASE_CMP_LSB        4
`define BASE_CMP_MSB        15
`define RAM_OP_CYC          2
`endif

//--- hdl/host_port_pkg.sv
// types shared by both ends of the asynchronous host port
// assumes the defines header is compiled alongside
package host_port_pkg;
    typedef logic [15:1] host_addr_t;
    typedef logic [15:0] host_data_t;
    typedef logic [1:0]  lane_sel_t;
    typedef logic [16:2] ram_addr_t;
    typedef logic [31:0] ram_data_t;
    typedef logic [3:0]  ram_we_t;
endpackage : host_port_pkg

//--- hdl/host_port_if.sv
// pin-level interface between the host bus and the controller
// open-drain ready and data bus levels are resolved in this interface, with pull-up defaults
`timescale 1ns/1ps
interface host_port_if;
    import host_port_pkg::*;
    host_addr_t addr;
    logic       addr_qualifier_n;
    lane_sel_t  byte_lane_sel_n;
    logic       addr_latch_strobe_n;
    logic       host_read_strobe_n;
    logic       host_write_strobe_n;
    logic       reset_pin;
    host_data_t data_host_out;
    host_data_t data_dev_out;
    logic       data_dev_oe;
    logic       access_ready_od_oe;
    logic       local_device_sel_n;
    logic       irq_out;
    // resolved levels: weak pull-ups on data, pull-up on ready
    wire  host_data_t data_bus = data_dev_oe ? data_dev_out :
                                 (!host_write_strobe_n ? data_host_out : 16'hffff);
    wire  logic       access_ready_od = !access_ready_od_oe;

    modport device (
        input  addr, addr_qualifier_n, byte_lane_sel_n, addr_latch_strobe_n,
        input  host_read_strobe_n, host_write_strobe_n, reset_pin, data_bus,
        output data_dev_out, data_dev_oe, access_ready_od_oe,
        output local_device_sel_n, irq_out
    );
    modport host (
        output addr, addr_qualifier_n, byte_lane_sel_n, addr_latch_strobe_n,
        output host_read_strobe_n, host_write_strobe_n, reset_pin, data_host_out,
        input  data_bus, access_ready_od, local_device_sel_n, irq_out
    );
endinterface : host_port_if

//--- hdl/pin_sync.sv
// three-stage pin synchroniser: output changes when stages two and three agree
// assumes an asynchronous input and a single core clock
`timescale 1ns/1ps
module pin_sync #(
    parameter int  W    = 1,
    parameter logic INIT = 1'b1
) (
    // clock and control
    input  wire logic         clock_i,
    input  wire logic         reset_i,
    input  wire logic         enable_i,
    // data
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] s1, s2, s3, out;
    logic [W-1:0] next_out;

    always_comb begin
        next_out = out;
        for (int i = 0; i < W; i++) begin
            if (s2[i] == s3[i]) begin
                next_out[i] = s2[i];
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            s1  <= {W{INIT}};
            s2  <= {W{INIT}};
            s3  <= {W{INIT}};
            out <= {W{INIT}};
        end else if (enable_i) begin
            s1  <= pin_i;
            s2  <= s1;
            s3  <= s2;
            out <= next_out;
        end
    end

    assign sync_o = out;
endmodule : pin_sync

//--- hdl/host_port_device.sv
// controller end of the asynchronous host port and buffer ram interface
// assumes host pins arrive asynchronously; core clock is the 25 mhz crystal
// Contract
// - decode only while qualifier is low
// - address bits 15..1 select register
// - byte lane selects set width, bytes
// - reset counts after 100ns continuous
// - open-drain ready stretches host cycles
// - ready release timed by crystal clock
// - ready held 100 to 150 ns
// - local select on base match
// - local select is purely combinational
// - strobe rising edge latches address, qualifier
// - interrupt pin enabled by routing field
// - drive data only on reads
// - buffer reads are full words
// - buffer writes per byte lane
// - host frames cycles with strobes
// - word address, output enable pulse
// - four byte write strobes
// - 25 MHz crystal clock supplied
`include "host_port_defines.svh"
`timescale 1ns/1ps
module host_port_device
    import host_port_pkg::*;
(
    // clock and control
    input  wire logic   clock_i,
    input  wire logic   enable_i,
    input  wire logic   reset_i,
    // host pins
    host_port_if.device hp,
    // configuration and register file side
    input  wire logic [7:0]  base_high_i,
    input  wire logic [1:0]  int_sel_i,
    input  wire logic        no_wait_i,
    input  wire logic        int_req_i,
    input  host_data_t       reg_rdata_i,
    output host_addr_t       reg_addr_o,
    output lane_sel_t        reg_lanes_o,
    output host_data_t       reg_wdata_o,
    output logic             reg_wr_o,
    output logic             reg_rd_o,
    output logic             core_reset_o,
    // buffer ram side
    input  wire logic        ram_req_i,
    input  wire logic        ram_write_i,
    input  ram_addr_t        ram_addr_i,
    input  ram_we_t          ram_lanes_i,
    input  ram_data_t        ram_wdata_i,
    input  ram_data_t        ram_rd_i,
    output logic             ram_done_o,
    output ram_data_t        ram_rdata_o,
    output ram_addr_t        buffer_ram_word_addr,
    output logic             buffer_ram_oe_n,
    output ram_we_t          buffer_ram_byte_we_n,
    output ram_data_t        ram_wd_o,
    output logic             ram_wd_oe_o
);
    // ----------------------------------------------------------------
    // local device decode
    // ----------------------------------------------------------------
    // unlatched combinational path
    assign hp.local_device_sel_n = !(!hp.addr_qualifier_n &&
        hp.addr[`BASE_CMP_MSB:`BASE_CMP_LSB] == {4'h0, base_high_i});

    // ----------------------------------------------------------------
    // synchronisers
    // ----------------------------------------------------------------
    logic       rd_n_s, wr_n_s, ads_n_s, rst_s;
    logic [2:0] strobes_s;
    pin_sync #(.W(3), .INIT(1'b1)) u_sync_strobe (
        .clock_i  (clock_i),
        .reset_i  (reset_i),
        .enable_i (enable_i),
        .pin_i    ({hp.host_read_strobe_n, hp.host_write_strobe_n,
                    hp.addr_latch_strobe_n}),
        .sync_o   (strobes_s)
    );
    assign {rd_n_s, wr_n_s, ads_n_s} = strobes_s;
    pin_sync #(.W(1), .INIT(1'b0)) u_sync_rst (
        .clock_i  (clock_i),
        .reset_i  (reset_i),
        .enable_i (enable_i),
        .pin_i    (hp.reset_pin),
        .sync_o   (rst_s)
    );

    // ----------------------------------------------------------------
    // host access state
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WAIT = 4'b0010,
        ST_DONE = 4'b0100,
        ST_END  = 4'b1000
    } acc_state_t;

    acc_state_t state, next_state;
    logic [2:0] rst_cnt, next_rst_cnt;
    logic       core_rst, next_core_rst;
    logic [2:0] rdy_cnt, next_rdy_cnt;
    logic       rdy_oe, next_rdy_oe;
    logic       ads_prev, next_ads_prev;
    logic       use_latch, next_use_latch;
    host_addr_t lat_addr, next_lat_addr;
    logic       lat_q_n, next_lat_q_n;
    host_addr_t acc_addr, next_acc_addr;
    lane_sel_t  acc_lanes, next_acc_lanes;
    logic       acc_read, next_acc_read;
    logic       do_wr, next_do_wr;
    logic       do_rd, next_do_rd;
    host_data_t wdata, next_wdata;
    host_data_t rdata, next_rdata;
    logic       d_oe, next_d_oe;
    logic       irq, next_irq;
    logic       qual_n;
    host_addr_t cur_addr;

    // latched values replace live pins once the strobe is in use
    assign cur_addr = use_latch ? lat_addr : hp.addr;
    assign qual_n   = use_latch ? lat_q_n  : hp.addr_qualifier_n;

    always_comb begin
        next_state     = state;
        next_rst_cnt   = rst_cnt;
        next_core_rst  = core_rst;
        next_rdy_cnt   = rdy_cnt;
        next_rdy_oe    = rdy_oe;
        next_ads_prev  = ads_n_s;
        next_use_latch = use_latch;
        next_lat_addr  = lat_addr;
        next_lat_q_n   = lat_q_n;
        next_acc_addr  = acc_addr;
        next_acc_lanes = acc_lanes;
        next_acc_read  = acc_read;
        next_do_wr     = 1'b0;
        next_do_rd     = 1'b0;
        next_wdata     = wdata;
        next_rdata     = rdata;
        next_d_oe      = d_oe;
        // interrupt routed only when field selects the pin
        next_irq       = int_req_i && (int_sel_i == `INT_SEL_PIN);
        // glitch filter on the reset pin
        if (!rst_s) begin
            next_rst_cnt  = 3'h0;
            next_core_rst = 1'b0;
        end else if (rst_cnt < 3'(`RESET_FILTER_CYC)) begin
            next_rst_cnt = rst_cnt + 3'h1;
        end else begin
            next_core_rst = 1'b1;
        end
        // capture on rising edge of latch strobe
        if (!ads_prev && ads_n_s) begin
            next_use_latch = 1'b1;
            next_lat_addr  = hp.addr;
            next_lat_q_n   = hp.addr_qualifier_n;
        end
        unique case (state)
            ST_IDLE: begin
                if (!qual_n && (!rd_n_s || !wr_n_s)) begin
                    next_acc_addr  = cur_addr;
                    next_acc_lanes = hp.byte_lane_sel_n;
                    next_acc_read  = !rd_n_s;
                    next_wdata     = hp.data_bus;
                    next_do_rd     = !rd_n_s;
                    // ready stretch unless zero-wait is set
                    next_rdy_oe    = !no_wait_i;
                    next_rdy_cnt   = 3'h0;
                    next_state     = ST_WAIT;
                end
            end
            ST_WAIT: begin
                next_rdy_cnt = rdy_cnt + 3'h1;
                if (rdy_cnt == 3'h0 && acc_read) begin
                    next_rdata = reg_rdata_i;
                    next_d_oe  = 1'b1;
                end
                if (rdy_cnt >= 3'(`READY_HOLD_CYC - 1)) begin
                    next_rdy_oe = 1'b0;
                    next_state  = ST_DONE;
                end
            end
            ST_DONE: begin
                if (rd_n_s && wr_n_s) begin
                    next_d_oe  = 1'b0;
                    next_do_wr = !acc_read;
                    next_state = ST_END;
                end
            end
            ST_END: begin
                next_state = ST_IDLE;
            end
        endcase
        // release data as soon as read strobe leaves
        if (rd_n_s) begin
            next_d_oe = 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state     <= ST_IDLE;
            rst_cnt   <= 3'h0;
            core_rst  <= 1'b0;
            rdy_cnt   <= 3'h0;
            rdy_oe    <= 1'b0;
            ads_prev  <= 1'b1;
            use_latch <= 1'b0;
            lat_addr  <= '0;
            lat_q_n   <= 1'b1;
            acc_addr  <= '0;
            acc_lanes <= 2'h3;
            acc_read  <= 1'b0;
            do_wr     <= 1'b0;
            do_rd     <= 1'b0;
            wdata     <= 16'h0000;
            rdata     <= 16'h0000;
            d_oe      <= 1'b0;
            irq       <= 1'b0;
        end else if (enable_i) begin
            state     <= next_state;
            rst_cnt   <= next_rst_cnt;
            core_rst  <= next_core_rst;
            rdy_cnt   <= next_rdy_cnt;
            rdy_oe    <= next_rdy_oe;
            ads_prev  <= next_ads_prev;
            use_latch <= next_use_latch;
            lat_addr  <= next_lat_addr;
            lat_q_n   <= next_lat_q_n;
            acc_addr  <= next_acc_addr;
            acc_lanes <= next_acc_lanes;
            acc_read  <= next_acc_read;
            do_wr     <= next_do_wr;
            do_rd     <= next_do_rd;
            wdata     <= next_wdata;
            rdata     <= next_rdata;
            d_oe      <= next_d_oe;
            irq       <= next_irq;
        end
    end

    assign hp.data_dev_out        = rdata;
    assign hp.data_dev_oe         = d_oe;
    assign hp.access_ready_od_oe  = rdy_oe;
    assign hp.irq_out             = irq;
    assign reg_addr_o             = acc_addr;
    assign reg_lanes_o            = acc_lanes;
    assign reg_wdata_o            = wdata;
    assign reg_wr_o               = do_wr;
    assign reg_rd_o               = do_rd;
    assign core_reset_o           = core_rst;

    // ----------------------------------------------------------------
    // buffer ram port
    // ----------------------------------------------------------------
    // write data is held on the bus one cycle past the strobe for hold time
    logic       ram_busy, next_ram_busy;
    logic [1:0] ram_cnt, next_ram_cnt;
    ram_addr_t  ram_a, next_ram_a;
    logic       roe_n, next_roe_n;
    ram_we_t    rwe_n, next_rwe_n;
    ram_data_t  ram_wd, next_ram_wd;
    logic       ram_oe, next_ram_oe;
    ram_data_t  ram_q, next_ram_q;
    logic       ram_done, next_ram_done;

    always_comb begin
        next_ram_busy = ram_busy;
        next_ram_cnt  = ram_cnt;
        next_ram_a    = ram_a;
        next_roe_n    = roe_n;
        next_rwe_n    = rwe_n;
        next_ram_wd   = ram_wd;
        next_ram_oe   = ram_oe;
        next_ram_q    = ram_q;
        next_ram_done = 1'b0;
        if (!ram_busy) begin
            next_ram_oe = 1'b0;
            if (ram_req_i) begin
                next_ram_busy = 1'b1;
                next_ram_cnt  = 2'h0;
                next_ram_a    = ram_addr_i;
                if (ram_write_i) begin
                    next_rwe_n  = ~ram_lanes_i;
                    next_ram_wd = ram_wdata_i;
                    next_ram_oe = 1'b1;
                end else begin
                    next_roe_n = 1'b0;
                end
            end
        end else begin
            next_ram_cnt = ram_cnt + 2'h1;
            if (ram_cnt == 2'(`RAM_OP_CYC - 1)) begin
                if (!roe_n) begin
                    next_ram_q = ram_rd_i;
                end
                next_roe_n    = 1'b1;
                next_rwe_n    = 4'hf;
                next_ram_busy = 1'b0;
                next_ram_done = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            ram_busy <= 1'b0;
            ram_cnt  <= 2'h0;
            ram_a    <= '0;
            roe_n    <= 1'b1;
            rwe_n    <= 4'hf;
            ram_wd   <= 32'h00000000;
            ram_oe   <= 1'b0;
            ram_q    <= 32'h00000000;
            ram_done <= 1'b0;
        end else if (enable_i) begin
            ram_busy <= next_ram_busy;
            ram_cnt  <= next_ram_cnt;
            ram_a    <= next_ram_a;
            roe_n    <= next_roe_n;
            rwe_n    <= next_rwe_n;
            ram_wd   <= next_ram_wd;
            ram_oe   <= next_ram_oe;
            ram_q    <= next_ram_q;
            ram_done <= next_ram_done;
        end
    end

    assign buffer_ram_word_addr = ram_a;
    assign buffer_ram_oe_n      = roe_n;
    assign buffer_ram_byte_we_n = rwe_n;
    assign ram_wd_o             = ram_wd;
    assign ram_wd_oe_o          = ram_oe;
    assign ram_rdata_o          = ram_q;
    assign ram_done_o           = ram_done;
endmodule : host_port_device

//--- hdl/host_port_host.sv
// host bus end: runs one register read or write per request
// assumes the controller answers through the open-drain ready line
`include "host_port_defines.svh"
`timescale 1ns/1ps
module host_port_host
    import host_port_pkg::*;
(
    // clock and control
    input  wire logic  clock_i,
    input  wire logic  enable_i,
    input  wire logic  reset_i,
    // host pins
    host_port_if.host  hp,
    // user side
    input  wire logic  req_i,
    input  wire logic  write_i,
    input  wire logic  use_latch_i,
    input  host_addr_t addr_i,
    input  lane_sel_t  lanes_n_i,
    input  host_data_t wdata_i,
    input  wire logic  reset_req_i,
    output host_data_t rdata_o,
    output logic       done_o,
    output logic       busy_o
);
    typedef enum logic [4:0] {
        H_IDLE = 5'b00001,
        H_ADS  = 5'b00010,
        H_STRB = 5'b00100,
        H_WAIT = 5'b01000,
        H_REL  = 5'b10000
    } host_state_t;

    host_state_t st, next_st;
    logic        rdy_s;
    logic [3:0]  cnt, next_cnt;
    host_addr_t  a, next_a;
    lane_sel_t   be, next_be;
    host_data_t  wd, next_wd, rd, next_rd;
    logic        wr, next_wr, ads, next_ads, rds, next_rds, wrs, next_wrs;
    logic        q, next_q, done, next_done;

    pin_sync #(.W(1), .INIT(1'b1)) u_sync_rdy (
        .clock_i  (clock_i),
        .reset_i  (reset_i),
        .enable_i (enable_i),
        .pin_i    (hp.access_ready_od),
        .sync_o   (rdy_s)
    );

    always_comb begin
        next_st = st; next_cnt = cnt; next_a = a; next_be = be; next_wd = wd;
        next_rd = rd; next_wr = wr; next_ads = ads; next_rds = rds;
        next_wrs = wrs; next_q = q; next_done = 1'b0;
        unique case (st)
            H_IDLE: begin
                if (req_i) begin
                    next_a = addr_i; next_be = lanes_n_i; next_wd = wdata_i;
                    next_wr = write_i; next_q = 1'b0; next_cnt = 4'h0;
                    next_ads = !use_latch_i;
                    next_st = H_ADS;
                end
            end
            H_ADS: begin
                next_rds = wr; next_wrs = !wr;
                next_st = H_STRB;
            end
            H_STRB: begin
                next_cnt = cnt + 4'h1;
                // latch strobe low for several cycles so the far end sees it
                if (cnt == 4'h2) begin
                    next_ads = 1'b1;
                end
                // long enough for ready to cross both synchronisers
                if (cnt == 4'h9) begin
                    next_st = H_WAIT;
                end
            end
            H_WAIT: begin
                if (rdy_s) begin
                    next_rd = hp.data_bus;
                    next_rds = 1'b1; next_wrs = 1'b1;
                    next_st = H_REL;
                end
            end
            H_REL: begin
                next_q = 1'b1; next_done = 1'b1;
                next_st = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            st <= H_IDLE; cnt <= 4'h0; a <= '0; be <= 2'h3; wd <= 16'h0000;
            rd <= 16'h0000; wr <= 1'b0; ads <= 1'b1; rds <= 1'b1; wrs <= 1'b1;
            q <= 1'b1; done <= 1'b0;
        end else if (enable_i) begin
            st <= next_st; cnt <= next_cnt; a <= next_a; be <= next_be;
            wd <= next_wd; rd <= next_rd; wr <= next_wr; ads <= next_ads;
            rds <= next_rds; wrs <= next_wrs; q <= next_q; done <= next_done;
        end
    end

    assign hp.addr                = a;
    assign hp.byte_lane_sel_n     = be;
    assign hp.addr_qualifier_n    = q;
    assign hp.addr_latch_strobe_n = ads;
    assign hp.host_read_strobe_n  = rds;
    assign hp.host_write_strobe_n = wrs;
    assign hp.data_host_out       = wd;
    assign hp.reset_pin           = reset_req_i;
    assign rdata_o                = rd;
    assign done_o                 = done;
    assign busy_o                 = (st != H_IDLE);
endmodule : host_port_host

//--- tb/host_port_chk.sv
// concurrent checks on the host port pins and the device's buffer ram side
// assumes one core clock and a synchronous active-high reset
`timescale 1ns/1ps
module host_port_chk
    import host_port_pkg::*;
(
    // clock and reset
    input wire logic       clock_i,
    input wire logic       reset_i,
    // host pins
    input wire host_addr_t addr,
    input wire logic       addr_qualifier_n,
    input wire logic       host_read_strobe_n,
    input wire logic       host_write_strobe_n,
    input wire logic       reset_pin,
    input wire logic       data_dev_oe,
    input wire logic       access_ready_od_oe,
    input wire logic       local_device_sel_n,
    input wire logic       irq_out,
    // device side
    input wire logic [7:0] base_high_i,
    input wire logic [1:0] int_sel_i,
    input wire logic       core_reset_o,
    input wire logic       buffer_ram_oe_n,
    input wire ram_we_t    buffer_ram_byte_we_n
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    // ----------------------------------------
    // checks
    // ----------------------------------------
    // run of high pin cycles; flag kept until the filtered reset falls
    logic [1:0] hi;
    logic       long_hi;
    always_ff @(posedge clock_i) begin
        hi      <= reset_i || !reset_pin ? 2'h0 : (hi == 2'h3 ? hi : hi + 2'h1);
        long_hi <= !reset_i && (hi == 2'h3 || (long_hi && !$fell(core_reset_o)));
    end
    a_reset_filter: assert property ($rose(core_reset_o) |-> long_hi)
        else $error("filtered reset rose after a short pin pulse");
    a_ldev_decode: assert property (local_device_sel_n == !(!addr_qualifier_n
        && addr[15:12] == 4'h0 && addr[11:4] == base_high_i)) else $error("local select wrong");
    a_ready_width: assert property ($rose(access_ready_od_oe) |->
        access_ready_od_oe[*3] ##1 !access_ready_od_oe) else $error("ready width wrong");
    a_ready_holds: assert property (access_ready_od_oe |->
        !(host_read_strobe_n && host_write_strobe_n)) else $error("cycle ended under ready");
    a_ready_qual: assert property ($rose(access_ready_od_oe) |-> !addr_qualifier_n)
        else $error("ready for unqualified access");
    a_drive_read: assert property ($rose(data_dev_oe) |->
        !host_read_strobe_n && host_write_strobe_n) else $error("data driven off read");
    a_no_drive_wr: assert property (!host_write_strobe_n |-> !data_dev_oe)
        else $error("data driven during write");
    a_strobe_excl: assert property (host_read_strobe_n || host_write_strobe_n)
        else $error("read and write strobes together");
    a_irq_route: assert property (int_sel_i != 2'h0 && $past(int_sel_i) != 2'h0 |->
        !irq_out) else $error("interrupt pin not routed but active");
    a_ram_word: assert property (!buffer_ram_oe_n |-> buffer_ram_byte_we_n == 4'hf)
        else $error("write lanes during ram read");
    a_oe_pulse: assert property ($fell(buffer_ram_oe_n) |->
        ##1 !buffer_ram_oe_n ##1 buffer_ram_oe_n) else $error("ram read pulse width wrong");
endmodule : host_port_chk

//--- tb/async_host_bus_interface_test.sv
// bench: host end and device end joined by one pin-level interface
// assumes a 25 mhz clock; the bench plays register file and buffer ram
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module async_host_bus_interface_test;
    import host_port_pkg::*;
    logic       clock_i, reset_i, enable_i, no_wait_i, int_req_i, req_i, write_i;
    logic       use_latch_i, reset_req_i, ram_req_i, ram_write_i, reg_wr_o, reg_rd_o;
    logic       core_reset_o, ram_done_o, buffer_ram_oe_n, ram_wd_oe_o, done_o, busy_o;
    logic [7:0] base_high_i;
    logic [1:0] int_sel_i;
    host_data_t reg_rdata_i, reg_wdata_o, wdata_i, rdata_o, wd;
    host_addr_t reg_addr_o, addr_i, wa, a;
    lane_sel_t  reg_lanes_o, lanes_n_i, wl;
    ram_addr_t  ram_addr_i, buffer_ram_word_addr, ra;
    ram_we_t    ram_lanes_i, buffer_ram_byte_we_n, we;
    ram_data_t  ram_wdata_i, ram_rd_i, ram_rdata_o, ram_wd_o, mem, wdo;
    ram_we_t    lt [3] = '{4'h1, 4'h3, 4'hf};
    int         errors = 0, n_tests = 0, cyc = 0, rdy = 0, r0, rst_seen = 0, n_rd = 0;
    host_port_if hp ();
    host_port_device i_host_port_device (.*);
    host_port_host i_host_port_host (.*);
    host_port_chk i_host_port_chk (.addr(hp.addr), .addr_qualifier_n(hp.addr_qualifier_n),
        .host_read_strobe_n(hp.host_read_strobe_n), .reset_pin(hp.reset_pin),
        .host_write_strobe_n(hp.host_write_strobe_n), .data_dev_oe(hp.data_dev_oe),
        .access_ready_od_oe(hp.access_ready_od_oe), .irq_out(hp.irq_out),
        .local_device_sel_n(hp.local_device_sel_n), .*);
    // released ram data lines do not keep the last word
    assign ram_rd_i = buffer_ram_oe_n ? ~mem : mem;
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        rdy <= rdy + int'(hp.access_ready_od_oe === 1'b1);
        n_rd <= n_rd + int'(reg_rd_o === 1'b1);
        if (reg_wr_o === 1'b1) begin
            {wa, wl, wd} <= {reg_addr_o, reg_lanes_o, reg_wdata_o};
        end
        if (buffer_ram_oe_n === 1'b0) ra <= buffer_ram_word_addr;
        if (buffer_ram_byte_we_n !== 4'hf) {we, wdo} <= {buffer_ram_byte_we_n, ram_wd_o};
        if (core_reset_o === 1'b1) rst_seen <= 1;
        if (cyc == 5000) begin
            errors++;
            test_done();
        end
    end
    task host_op(input logic w, input host_addr_t ad, input lane_sel_t l, input host_data_t d);
        {write_i, addr_i, lanes_n_i, wdata_i, req_i} <= {w, ad, l, d, 1'b1};
        @(posedge clock_i) req_i <= 1'b0;
        for (int i = 0; i < 100 && done_o !== 1'b1; i++) @(posedge clock_i);
        `CHK(done_o, 1'b1)
        repeat (8) @(posedge clock_i);
    endtask : host_op
    task ram_op(input logic w, input ram_addr_t ad, input ram_we_t l, input ram_data_t d);
        {ram_write_i, ram_addr_i, ram_lanes_i, ram_wdata_i, ram_req_i} <= {w, ad, l, d, 1'b1};
        @(posedge clock_i) ram_req_i <= 1'b0;
        for (int i = 0; i < 20 && ram_done_o !== 1'b1; i++) @(posedge clock_i);
        `CHK(ram_done_o, 1'b1)
        @(posedge clock_i);
    endtask : ram_op
    task test_done;
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        {reset_i, enable_i, no_wait_i, int_req_i, req_i, write_i} = 6'b110000;
        {use_latch_i, reset_req_i, ram_req_i, ram_write_i, int_sel_i} = 6'b000001;
        {base_high_i, reg_rdata_i, mem} = {8'h3c, 16'ha55a, 32'h1234abcd};
        {addr_i, lanes_n_i, wdata_i, ram_addr_i, ram_lanes_i, ram_wdata_i} = '0;
        repeat (8) @(posedge clock_i);
        reset_i <= 1'b0;
        repeat (8) @(posedge clock_i);
        for (int i = 0; i < 3; i++) begin
            a = {4'h0, 8'h3c, 3'(i + 1)};
            host_op(1'b1, a, 2'(i), 16'h5a00 + 16'(i));
            `CHK({wa, wl, wd}, {a, 2'(i), 16'h5a00 + 16'(i)})
        end
        r0 = rdy;
        host_op(1'b0, a, 2'h0, 16'h0);
        `CHK({rdata_o, 8'(rdy - r0)}, {16'ha55a, 8'h03})
        no_wait_i <= 1'b1;
        r0 = rdy;
        host_op(1'b0, a, 2'h0, 16'h0);
        `CHK({rdata_o, 8'(rdy - r0)}, {16'ha55a, 8'h00})
        `CHK(n_rd, 2)
        no_wait_i <= 1'b0;
        ram_op(1'b0, 15'h1a5b, 4'h0, 32'h0);
        `CHK({ram_rdata_o, ra}, {32'h1234abcd, 15'h1a5b})
        for (int i = 0; i < 3; i++) begin
            ram_op(1'b1, 15'h0100 + 15'(i), lt[i], 32'hc0de0000 + 32'(i));
            `CHK({we, wdo}, {~lt[i], 32'hc0de0000 + 32'(i)})
        end
        int_req_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        `CHK(hp.irq_out, 1'b0)
        int_sel_i <= 2'h0;
        repeat (4) @(posedge clock_i);
        `CHK(hp.irq_out, 1'b1)
        reset_req_i <= 1'b1;
        @(posedge clock_i) reset_req_i <= 1'b0;
        repeat (12) @(posedge clock_i);
        `CHK(rst_seen, 0)
        reset_req_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        reset_req_i <= 1'b0;
        repeat (12) @(posedge clock_i);
        `CHK(rst_seen, 1)
        use_latch_i <= 1'b1;
        a = {4'h0, 8'h3c, 3'h6};
        host_op(1'b1, a, 2'h0, 16'h0bad);
        `CHK({wa, wl, wd}, {a, 2'h0, 16'h0bad})
        use_latch_i <= 1'b0;
        host_op(1'b1, a ^ 15'h1, 2'h0, 16'h0bad);
        `CHK(wa, a)
        test_done();
    end
endmodule : async_host_bus_interface_test
